/* core/pcat_counter.sv */
// array counter timebase: 16-bit counter, snapshot, timebase select, overflow flag
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "pcat_map.svh"
module pcat_counter
	import pcat_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic timer0Overflow,
	input wire logic externalCountInput,
	input wire logic extOscDiv8,
	input wire logic rtcOscDiv8,
	input wire logic cpuIdle,
	output logic overflowIrq
);
	logic [15:0] count_q;
	logic [7:0] snapshot_q;
	pcat_mode_s mode_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic irq_q;
	logic [3:0] div_q;
	logic [1:0] ecix_q;
	// slow oscillator ticks arrive unrelated to sys_clk; two flops before any use
	wire [1:0] oscIn = {rtcOscDiv8, extOscDiv8};
	logic [1:0] oscRise;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSync
			logic [2:0] sync_q;
			// stage 0 feeds only stage 1; stage 2 is the edge reference
			always_ff @(posedge sys_clk) begin
				if (!rst_b) begin
					sync_q <= 3'h0;
				end else if (clkEn) begin
					sync_q <= {sync_q[1:0], oscIn[g]};
				end
			end
			assign oscRise[g] = sync_q[1] & ~sync_q[2];
		end
	endgenerate

	// bus decode
	wire access = wb_cyc_i & wb_stb_i & ~ack_q;
	wire rdAccess = access & ~wb_we_i;
	wire wrAccess = access & wb_we_i & wb_sel_i[0];
	wire hitLow = wb_adr_i == `PCAT_OFF_LOW;
	wire hitHigh = wb_adr_i == `PCAT_OFF_HIGH;
	wire hitMode = wb_adr_i == `PCAT_OFF_MODE;
	wire rdLow = rdAccess & hitLow;
	wire wrMode = wrAccess & hitMode;

	// timebase tick generation
	wire [3:0] divLast = (mode_q.timebaseSelect == PCAT_TB_DIV12) ? `PCAT_DIV12_LAST : `PCAT_DIV4_LAST;
	wire divWrap = div_q >= divLast;
	wire eciFall = ecix_q[1] & ~ecix_q[0];
	wire xoscRise = oscRise[0];
	wire rtcRise = oscRise[1];
	logic tick;
	always_comb begin
		unique case (mode_q.timebaseSelect)
			PCAT_TB_DIV12: tick = divWrap;
			PCAT_TB_DIV4: tick = divWrap;
			PCAT_TB_T0OVF: tick = timer0Overflow;
			PCAT_TB_EXTIN: tick = eciFall;
			PCAT_TB_SYSCLK: tick = 1'b1;
			PCAT_TB_XOSC8: tick = xoscRise;
			PCAT_TB_RTC8: tick = rtcRise;
			PCAT_TB_RSVD: tick = 1'b0;
		endcase
	end
	// suspend only when asked; reads do not enter this term
	wire runEn = ~(cpuIdle & mode_q.idleSuspend);
	wire step = tick & runEn;
	wire wrap = step & (count_q == 16'hFFFF);
	wire [15:0] countNext = count_q + 16'h0001;

	// low byte write with sel[0]; counter bytes are writable like the timer bytes
	wire wrLow = wrAccess & hitLow;
	wire wrHigh = wrAccess & hitHigh;
	logic [15:0] count_d;
	always_comb begin
		count_d = step ? countNext : count_q;
		if (wrLow) begin
			count_d[7:0] = wb_dat_i[7:0];
		end
		if (wrHigh) begin
			count_d[15:8] = wb_dat_i[7:0];
		end
	end

	// flag: hardware set beats software clear; no clear on interrupt service
	wire flagClr = wrMode & ~wb_dat_i[`PCAT_MODE_FLAG_BIT];
	wire flag_d = wrap | (mode_q.overflowFlag & ~flagClr);
	pcat_mode_s mode_d;
	always_comb begin
		mode_d = mode_q;
		mode_d.overflowFlag = flag_d;
		if (wrMode) begin
			mode_d.overflowIrqEnable = wb_dat_i[`PCAT_MODE_IRQEN_BIT];
			mode_d.timebaseSelect = pcat_tb_e'(wb_dat_i[`PCAT_MODE_SEL_LSB +: 3]);
			mode_d.idleSuspend = wb_dat_i[`PCAT_MODE_IDLE_BIT];
		end
	end

	// read mux; high byte reads the snapshot, not the live byte
	wire [7:0] modeByte = {2'h0, mode_q.idleSuspend, mode_q.timebaseSelect, mode_q.overflowIrqEnable,
		mode_q.overflowFlag};
	wire [7:0] rdByte = hitLow ? count_q[7:0] : hitHigh ? snapshot_q : hitMode ? modeByte : 8'h00;
	wire [31:0] rdat_d = rdAccess ? {24'h000000, rdByte} : 32'h00000000;

	// both bytes live in one register so a carry never shows half done
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count_q <= 16'h0000;
		end else if (clkEn) begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			snapshot_q <= `PCAT_RESET_BYTE;
		end else if (clkEn && rdLow) begin
			snapshot_q <= count_q[15:8];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_q <= '0;
		end else if (clkEn) begin
			mode_q <= mode_d;
		end
	end

	// one registered answer per request, acked the cycle after the strobe; ack blocks a repeat of the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else if (clkEn) begin
			ack_q <= access;
			rdat_q <= rdat_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else if (clkEn) begin
			irq_q <= flag_d & mode_d.overflowIrqEnable;
		end
	end

	// divider runs in every timebase mode, held only by idle suspend, so a mode switch costs at most one short period
	wire [3:0] divNext = divWrap ? 4'h0 : (runEn ? div_q + 4'h1 : div_q);
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_q <= 4'h0;
		end else if (clkEn) begin
			div_q <= divNext;
		end
	end

	// reset value matches the idle low level, so no false edge after reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ecix_q <= 2'h0;
		end else if (clkEn) begin
			ecix_q <= {ecix_q[0], externalCountInput};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign overflowIrq = irq_q;

	// checks
	snap_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rdLow && clkEn |=> snapshot_q == $past(count_q[15:8])) else $error("snapshot not taken on low read");
	high_snap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rdAccess && hitHigh && clkEn |=> wb_ack_o && wb_dat_o[7:0] == $past(snapshot_q))
		else $error("high read did not return snapshot");
	read_nodist_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && rdAccess && !step |=> count_q == $past(count_q)) else $error("read disturbed counter");
	step_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && step && !wrLow && !wrHigh |=> count_q == $past(count_q) + 16'h0001)
		else $error("counter did not step by one");
	sysclk_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_SYSCLK && runEn |-> tick) else $error("sysclk timebase missing tick");
	rsvd_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_RSVD |-> !tick) else $error("reserved code ticked");
	ext_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_EXTIN && tick |-> $past(externalCountInput, 2) && !$past(externalCountInput))
		else $error("external tick without falling edge");
	wrap_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && wrap |=> mode_q.overflowFlag) else $error("wrap did not set flag");
	flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && mode_q.overflowFlag && !wrMode |=> mode_q.overflowFlag) else $error("flag cleared by hardware");
	irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		overflowIrq |-> $past(mode_d.overflowIrqEnable) && $past(flag_d)) else $error("irq without enable");
	idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && cpuIdle && mode_q.idleSuspend && !wrLow && !wrHigh |=> count_q == $past(count_q))
		else $error("counted while idle suspended");
	low_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rdLow && clkEn |=> wb_ack_o && wb_dat_o[7:0] == $past(count_q[7:0]))
		else $error("low read returned wrong byte");
	upper_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits not zero");
	write_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && wrLow |=> count_q[7:0] == $past(wb_dat_i[7:0])) else $error("low byte write lost");
	ack_once_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wb_ack_o && clkEn |=> !wb_ack_o) else $error("ack longer than one cycle");
	snap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!(clkEn && rdLow) |=> snapshot_q == $past(snapshot_q)) else $error("snapshot changed without low read");
	t0_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_T0OVF |-> tick == timer0Overflow)
		else $error("timer0 overflow tick mismatch");
	div_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mode_q.timebaseSelect == PCAT_TB_DIV4 || mode_q.timebaseSelect == PCAT_TB_DIV12) && tick
		|-> div_q == divLast) else $error("divided tick off its period");
	osc_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_XOSC8 && tick |-> $past(extOscDiv8, 2) && !$past(extOscDiv8, 3))
		else $error("oscillator tick without synchronised edge");
	rtc_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_RTC8 && tick |-> $past(rtcOscDiv8, 2) && !$past(rtcOscDiv8, 3))
		else $error("rtc tick without synchronised edge");
	flag_nowrap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && !mode_q.overflowFlag && !wrap |=> !mode_q.overflowFlag) else $error("flag set without wrap");
	irq_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		overflowIrq == (mode_q.overflowFlag && mode_q.overflowIrqEnable)) else $error("irq not flag and enable");
	flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && wrMode && !wb_dat_i[`PCAT_MODE_FLAG_BIT] && !wrap |=> !mode_q.overflowFlag)
		else $error("software clear ignored");
	idle_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && cpuIdle && !mode_q.idleSuspend && tick && !wrLow && !wrHigh |=> count_q == $past(count_q) + 16'h0001)
		else $error("stopped counting in idle");
	carry_both_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clkEn && step && count_q[7:0] == 8'hFF && !wrLow && !wrHigh
		|=> count_q[7:0] == 8'h00 && count_q[15:8] == $past(count_q[15:8]) + 8'h01)
		else $error("carry into high byte lost");
	freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!clkEn |=> count_q == $past(count_q) && mode_q == $past(mode_q)) else $error("state moved while frozen");
	wrap_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) wrap && clkEn);
	div_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_DIV12 && step);
	snap_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) rdLow ##[1:8] (rdAccess && hitHigh));
	ext_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
		mode_q.timebaseSelect == PCAT_TB_EXTIN && step);
	irq_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(overflowIrq));
endmodule

/* core/pcat_map.svh */
// register offsets, field positions, reset values and divider counts for the array counter timebase
`ifndef PCAT_MAP_SVH
`define PCAT_MAP_SVH
`define PCAT_OFF_LOW 4'h0
`define PCAT_OFF_HIGH 4'h4
`define PCAT_OFF_MODE 4'h8
`define PCAT_MODE_FLAG_BIT 0
`define PCAT_MODE_IRQEN_BIT 1
`define PCAT_MODE_SEL_LSB 2
`define PCAT_MODE_IDLE_BIT 5
`define PCAT_RESET_BYTE 8'h00
`define PCAT_RESET_SEL 3'h0
`define PCAT_DIV12_LAST 4'hB
`define PCAT_DIV4_LAST 4'h3
`endif

/* core/pcat_pkg.sv */
// types for the array counter timebase
package pcat_pkg;
	typedef enum logic [2:0] {
		PCAT_TB_DIV12 = 3'h0,
		PCAT_TB_DIV4 = 3'h1,
		PCAT_TB_T0OVF = 3'h2,
		PCAT_TB_EXTIN = 3'h3,
		PCAT_TB_SYSCLK = 3'h4,
		PCAT_TB_XOSC8 = 3'h5,
		PCAT_TB_RTC8 = 3'h6,
		PCAT_TB_RSVD = 3'h7
	} pcat_tb_e;
	typedef struct packed {
		logic idleSuspend;
		pcat_tb_e timebaseSelect;
		logic overflowIrqEnable;
		logic overflowFlag;
	} pcat_mode_s;
	typedef struct packed {
		logic [3:0] adr;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
	} pcat_wbreq_s;
endpackage

/* tb/test_array_counter_timebase.sv */
// self-checking bench for the array counter timebase
`timescale 1ns/1ns
module test_array_counter_timebase;
	import pcat_pkg::*;
	logic sysClk = 1'b0;
	logic rstB = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic idle = 1'b0;
	logic en = 1'b1;
	logic [3:0] src = 4'h0;
	logic [3:0] adr = 4'h0;
	logic [31:0] datI = 32'h0;
	logic [31:0] datO;
	logic [31:0] rd;
	logic ack;
	logic irq;
	int fails = 0;
	int nChecks = 0;
	always #5 sysClk = ~sysClk;
	pcat_counter i_pcat_counter (.sys_clk(sysClk), .rst_b(rstB), .clkEn(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
		.timer0Overflow(src[0]), .externalCountInput(src[1]), .extOscDiv8(src[2]), .rtcOscDiv8(src[3]),
		.cpuIdle(idle), .overflowIrq(irq));
	task results;
		$display("checks %0d mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// single classic cycle; no cycle count assumed, the bound only cuts a hang
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge sysClk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= {24'h0, d};
		k = 0;
		do begin
			@(posedge sysClk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) begin
			fails++;
			results();
		end
	endtask
	task rdChk(input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	// code 7 stops counting, so the bytes can be preset without racing ticks
	task zero;
		bus(1'b1, 4'h8, 8'h1C);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b1, 4'h4, 8'h00);
	endtask
	// one tick per pulse: t0 high one cycle, the others a slow full period
	task pulse(input int w, input int n);
		repeat (n) begin
			@(posedge sysClk);
			src[w] <= 1'b1;
			repeat (w == 0 ? 1 : 4) @(posedge sysClk);
			src[w] <= 1'b0;
			repeat (6) @(posedge sysClk);
		end
	endtask
	task tRegs;
		rdChk(4'h8, 8'h00);
		rdChk(4'hC, 8'h00);
		$display("registers done");
	endtask
	task tSnap;
		zero();
		bus(1'b1, 4'h0, 8'h34);
		bus(1'b1, 4'h4, 8'h12);
		rdChk(4'h0, 8'h34);
		bus(1'b1, 4'h4, 8'h56);
		rdChk(4'h4, 8'h12);
		rdChk(4'h0, 8'h34);
		rdChk(4'h4, 8'h56);
		$display("snapshot done");
	endtask
	task tSrc;
		logic [2:0] code [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
		for (int i = 0; i < 4; i++) begin
			zero();
			bus(1'b1, 4'h8, {3'h0, code[i], 2'h0});
			pulse(i, 3);
			bus(1'b1, 4'h8, 8'h1C);
			rdChk(4'h0, 8'h03);
			rdChk(4'h4, 8'h00);
		end
		$display("timebases done");
	endtask
	task tOvf;
		zero();
		bus(1'b1, 4'h0, 8'hFF);
		bus(1'b1, 4'h4, 8'hFF);
		bus(1'b1, 4'h8, 8'h12);
		bus(1'b1, 4'h8, 8'h1F);
		rdChk(4'h8, 8'h1F);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 4'h8, 8'h1D);
		rdChk(4'h8, 8'h1D);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 4'h8, 8'h1C);
		rdChk(4'h8, 8'h1C);
		$display("overflow done");
	endtask
	task tIdle;
		zero();
		idle <= 1'b1;
		bus(1'b1, 4'h8, 8'h30);
		repeat (10) @(posedge sysClk);
		bus(1'b1, 4'h8, 8'h3C);
		rdChk(4'h0, 8'h00);
		zero();
		bus(1'b1, 4'h8, 8'h10);
		repeat (9) @(posedge sysClk);
		bus(1'b1, 4'h8, 8'h1C);
		rdChk(4'h0, 8'h0C);
		idle <= 1'b0;
		$display("idle done");
	endtask
	// windows are whole divider periods, so the divider phase does not matter
	task tDiv;
		logic [2:0] code [3] = '{3'h0, 3'h1, 3'h4};
		int waitN [3] = '{21, 9, 9};
		logic [7:0] expN [3] = '{8'h02, 8'h03, 8'h0C};
		for (int i = 0; i < 3; i++) begin
			zero();
			bus(1'b1, 4'h8, {3'h0, code[i], 2'h0});
			repeat (waitN[i]) @(posedge sysClk);
			bus(1'b1, 4'h8, 8'h1C);
			rdChk(4'h0, expN[i]);
		end
		$display("dividers done");
	endtask
	task tClk;
		zero();
		bus(1'b1, 4'h8, 8'h10);
		en <= 1'b0;
		repeat (5) @(posedge sysClk);
		en <= 1'b1;
		repeat (4) @(posedge sysClk);
		bus(1'b1, 4'h8, 8'h1C);
		rdChk(4'h0, 8'h07);
		bus(1'b1, 4'h8, 8'h12);
		rstB <= 1'b0;
		repeat (2) @(posedge sysClk);
		rstB <= 1'b1;
		rdChk(4'h8, 8'h00);
		rdChk(4'h0, 8'h00);
		chk({31'h0, irq}, 32'h0);
		$display("enable and reset done");
	endtask
	initial begin
		repeat (20) @(posedge sysClk);
		rstB <= 1'b1;
		tRegs();
		tSnap();
		tSrc();
		tOvf();
		tIdle();
		tDiv();
		tClk();
		results();
	end
endmodule
